/* File: rtl/ptif_regs.vh */
// Register map, bit positions and reset values of the top interrupt flag block
`ifndef PTIF_REGS_VH
`define PTIF_REGS_VH

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define PTIF_ADDR_FLAGS_HIGH    8'h19
`define PTIF_ADDR_FLAGS_LOW     8'h1A
`define PTIF_ADDR_TOP_STATUS    8'h1D

// ----------------------------------------------------------------------------
// Field positions in top_interrupt_flags_high
// ----------------------------------------------------------------------------
`define PTIF_BIT_SYNC_CLK       4
`define PTIF_BIT_TSD            3
`define PTIF_BIT_TWARN          2
`define PTIF_BIT_OVP            1
`define PTIF_BIT_MEAS           0
`define PTIF_FLAGS_HIGH_MSB     4
`define PTIF_FLAGS_HIGH_W       5

// ----------------------------------------------------------------------------
// Field positions in top_interrupt_flags_low and the top status register
// ----------------------------------------------------------------------------
`define PTIF_BIT_RESET_EVENT    0
`define PTIF_BIT_STAT_SYNC_CLK  4
`define PTIF_BIT_STAT_TSD       3
`define PTIF_BIT_STAT_TWARN     2
`define PTIF_BIT_STAT_OVP       1

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define PTIF_FLAGS_HIGH_RESET   5'h00
`define PTIF_BYTE_ZERO          8'h00

`endif

/* File: rtl/ptif_top.v */
// Top-level latched interrupt flags, live status and protective shutdown
//
// Function
// RULE_01: Thermal shutdown sets bit 3, kills regulators, outputs
// RULE_02: Thermal shutdown flag blocks all regulator enables
// RULE_03: Live thermal shutdown shown in status register
// RULE_04: Thermal warning latched bit 2, live status mirrored
// RULE_05: Over-voltage sets bit 1, kills regulators, outputs
// RULE_06: New current result sets bit 0
// RULE_07: Result flag holds until host writes one
// RULE_08: Supply undervoltage or host reset sets reset flag
// RULE_09: Reset event disables regulators, defaults registers
// RULE_10: Restart startup; reset flag holds until cleared
// RULE_11: Reset register bits 7:1 reserved, read zero
// RULE_12: Sync clock appear or vanish sets bit 4
// RULE_13: Flags clear on one, zero keeps, events reassert
`timescale 1ns/1ns
`include "ptif_regs.vh"

module ptif_top #(
    parameter NUM_REG = 4
) (
    input  wire               CLK,
    input  wire               RESETN,
    input  wire               CE,
    input  wire [7:0]         REG_ADDR,
    input  wire               REG_WR,
    input  wire [7:0]         REG_WDATA,
    input  wire               REG_RD,
    output reg  [7:0]         REG_RDATA,
    input  wire               SYNC_CLK_PRESENT,
    input  wire               THERMAL_SHUTDOWN,
    input  wire               THERMAL_WARNING,
    input  wire               INPUT_OVERVOLTAGE,
    input  wire               CURRENT_RESULT_WRITTEN,
    input  wire               ANALOG_SUPPLY_LOW,
    input  wire               HOST_RESET_REQUEST,
    input  wire [NUM_REG-1:0] REGULATOR_REQUEST,
    output reg  [NUM_REG-1:0] REGULATOR_ENABLE,
    input  wire               GENERAL_OUTPUT_A_REQUEST,
    input  wire               GENERAL_OUTPUT_B_REQUEST,
    output reg                GENERAL_OUTPUT_A,
    output reg                GENERAL_OUTPUT_B,
    output reg                REGISTERS_DEFAULT,
    output reg                STARTUP_RESTART
);

    // ------------------------------------------------------------------------
    // Write-one-to-clear with set priority
    // ------------------------------------------------------------------------
    function [`PTIF_FLAGS_HIGH_MSB:0] w1c_update;
        input [`PTIF_FLAGS_HIGH_MSB:0] flags;
        input                          hit;
        input [`PTIF_FLAGS_HIGH_MSB:0] wdata;
        input [`PTIF_FLAGS_HIGH_MSB:0] set;
        begin
            // A set in the same cycle as a clear wins, so no event is lost
            w1c_update = (flags & ~({`PTIF_FLAGS_HIGH_W{hit}} & wdata)) | set;
        end
    endfunction

    // ------------------------------------------------------------------------
    // State and edge history
    // ------------------------------------------------------------------------
    reg [`PTIF_FLAGS_HIGH_MSB:0] flags_high;
    reg                          reset_event_flag;
    reg                          prev_sync;
    reg                          prev_tsd;
    reg                          prev_warn;
    reg                          prev_ovp;
    reg                          prev_uv;
    reg [NUM_REG-1:0]            prev_req;
    reg                          prev_out_a;
    reg                          prev_out_b;

    // ------------------------------------------------------------------------
    // Register write decode
    // ------------------------------------------------------------------------
    wire wr_high = REG_WR && (REG_ADDR == `PTIF_ADDR_FLAGS_HIGH);
    wire wr_low  = REG_WR && (REG_ADDR == `PTIF_ADDR_FLAGS_LOW);

    // ------------------------------------------------------------------------
    // Event detection
    // ------------------------------------------------------------------------
    wire ev_sync  = SYNC_CLK_PRESENT ^ prev_sync;                       // RULE_12
    wire ev_tsd   = THERMAL_SHUTDOWN & ~prev_tsd;                       // RULE_01
    wire ev_warn  = THERMAL_WARNING & ~prev_warn;                       // RULE_04
    wire ev_ovp   = INPUT_OVERVOLTAGE & ~prev_ovp;                      // RULE_05
    // Supply loss counts on its rising edge; a host request counts in every cycle it is high
    wire ev_reset = (ANALOG_SUPPLY_LOW & ~prev_uv) | HOST_RESET_REQUEST; // RULE_08
    wire trip     = ev_tsd | ev_ovp | ev_reset;

    wire [`PTIF_FLAGS_HIGH_MSB:0] set_high;
    assign set_high[`PTIF_BIT_SYNC_CLK] = ev_sync;                      // RULE_12
    assign set_high[`PTIF_BIT_TSD]      = ev_tsd;                       // RULE_01
    assign set_high[`PTIF_BIT_TWARN]    = ev_warn;                      // RULE_04
    assign set_high[`PTIF_BIT_OVP]      = ev_ovp;                       // RULE_05
    assign set_high[`PTIF_BIT_MEAS]     = CURRENT_RESULT_WRITTEN;       // RULE_06

    // Enables are refused while the latched shutdown flag stands
    wire enable_block = flags_high[`PTIF_BIT_TSD] | trip;               // RULE_02

    // ------------------------------------------------------------------------
    // Latched flags and edge history
    // ------------------------------------------------------------------------
    always @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            flags_high       <= `PTIF_FLAGS_HIGH_RESET;
            reset_event_flag <= 1'b0;
            prev_sync        <= 1'b0;
            prev_tsd         <= 1'b0;
            prev_warn        <= 1'b0;
            prev_ovp         <= 1'b0;
            prev_uv          <= 1'b0;
        end else if (CE) begin
            // Edge history freezes with the flags, so a level change that still stands when CE returns is caught; a pulse wholly within CE low is lost
            prev_sync <= SYNC_CLK_PRESENT;
            prev_tsd  <= THERMAL_SHUTDOWN;
            prev_warn <= THERMAL_WARNING;
            prev_ovp  <= INPUT_OVERVOLTAGE;
            prev_uv   <= ANALOG_SUPPLY_LOW;
            if (ev_reset) begin
                // Defaults return, but events of this cycle still land
                flags_high <= set_high;                                 // RULE_09
            end else begin
                flags_high <= w1c_update(flags_high, wr_high,
                                         REG_WDATA[`PTIF_FLAGS_HIGH_MSB:0],
                                         set_high); // RULE_07 RULE_13
            end
            // The reset flag outlives the default load so the host can see it
            if (ev_reset) begin
                reset_event_flag <= 1'b1;                               // RULE_08 RULE_10
            end else if (wr_low && REG_WDATA[`PTIF_BIT_RESET_EVENT]) begin
                reset_event_flag <= 1'b0;                               // RULE_10
            end
        end
    end

    // ------------------------------------------------------------------------
    // Regulator enables: taken on a request edge, dropped on a trip
    // ------------------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < NUM_REG; g = g + 1) begin : g_reg
            always @(posedge CLK or negedge RESETN) begin
                if (!RESETN) begin
                    REGULATOR_ENABLE[g] <= 1'b0;
                    prev_req[g]         <= 1'b0;
                end else if (CE) begin
                    prev_req[g] <= REGULATOR_REQUEST[g];
                    // A trip beats a fresh request edge; the request must fall and rise again
                    if (trip || !REGULATOR_REQUEST[g]) begin
                        REGULATOR_ENABLE[g] <= 1'b0;                    // RULE_01 RULE_05 RULE_09
                    end else if (!prev_req[g] && !enable_block) begin
                        REGULATOR_ENABLE[g] <= 1'b1;                    // RULE_02
                    end
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------------------
    // General purpose outputs, forced low on a trip
    // ------------------------------------------------------------------------
    always @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            GENERAL_OUTPUT_A  <= 1'b0;
            GENERAL_OUTPUT_B  <= 1'b0;
            prev_out_a        <= 1'b0;
            prev_out_b        <= 1'b0;
            REGISTERS_DEFAULT <= 1'b0;
            STARTUP_RESTART   <= 1'b0;
        end else if (CE) begin
            prev_out_a <= GENERAL_OUTPUT_A_REQUEST;
            prev_out_b <= GENERAL_OUTPUT_B_REQUEST;
            // Outputs follow request edges like the enables, so a trip stays put
            if (trip || !GENERAL_OUTPUT_A_REQUEST) begin
                GENERAL_OUTPUT_A <= 1'b0;                               // RULE_01 RULE_05
            end else if (!prev_out_a) begin
                GENERAL_OUTPUT_A <= 1'b1;
            end
            if (trip || !GENERAL_OUTPUT_B_REQUEST) begin
                GENERAL_OUTPUT_B <= 1'b0;                               // RULE_01 RULE_05
            end else if (!prev_out_b) begin
                GENERAL_OUTPUT_B <= 1'b1;
            end
            REGISTERS_DEFAULT <= ev_reset;                              // RULE_09
            STARTUP_RESTART   <= ev_reset;                              // RULE_10
        end
    end

    // ------------------------------------------------------------------------
    // Read port
    // ------------------------------------------------------------------------
    // Unmapped addresses and reserved bits read as zero
    reg [7:0] next_rdata;
    always @* begin
        next_rdata = `PTIF_BYTE_ZERO;
        case (REG_ADDR)
            `PTIF_ADDR_FLAGS_HIGH: begin
                next_rdata[`PTIF_FLAGS_HIGH_MSB:0] = flags_high;
            end
            `PTIF_ADDR_FLAGS_LOW: begin
                next_rdata[`PTIF_BIT_RESET_EVENT] = reset_event_flag;   // RULE_11
            end
            `PTIF_ADDR_TOP_STATUS: begin
                next_rdata[`PTIF_BIT_STAT_SYNC_CLK] = SYNC_CLK_PRESENT;
                next_rdata[`PTIF_BIT_STAT_TSD]      = THERMAL_SHUTDOWN;  // RULE_03
                next_rdata[`PTIF_BIT_STAT_TWARN]    = THERMAL_WARNING;   // RULE_04
                next_rdata[`PTIF_BIT_STAT_OVP]      = INPUT_OVERVOLTAGE;
            end
            default: begin
                next_rdata = `PTIF_BYTE_ZERO;
            end
        endcase
    end

    always @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            REG_RDATA <= `PTIF_BYTE_ZERO;
        end else if (CE && REG_RD) begin
            REG_RDATA <= next_rdata;
        end
    end

endmodule // ptif_top

/* File: verification/ptif_monitor.sv */
// Port-level assertions for the top interrupt flag block
`timescale 1ns/1ns
`include "ptif_regs.vh"
module ptif_monitor #(parameter NUM_REG = 4) (
    input wire               CLK,
    input wire               RESETN,
    input wire               CE,
    input wire [7:0]         REG_ADDR,
    input wire               REG_WR,
    input wire               REG_RD,
    input wire [7:0]         REG_RDATA,
    input wire               THERMAL_SHUTDOWN,
    input wire               THERMAL_WARNING,
    input wire               INPUT_OVERVOLTAGE,
    input wire               CURRENT_RESULT_WRITTEN,
    input wire               ANALOG_SUPPLY_LOW,
    input wire               HOST_RESET_REQUEST,
    input wire [NUM_REG-1:0] REGULATOR_ENABLE,
    input wire               GENERAL_OUTPUT_A,
    input wire               GENERAL_OUTPUT_B,
    input wire               REGISTERS_DEFAULT,
    input wire               STARTUP_RESTART
);
// ----
// Checks
// ----
default clocking @(posedge CLK); endclocking
default disable iff (!RESETN);
wire all_off = REGULATOR_ENABLE == 0 && !GENERAL_OUTPUT_A && !GENERAL_OUTPUT_B;
wire quiet = CE && !REG_WR && !HOST_RESET_REQUEST && !ANALOG_SUPPLY_LOW;
sequence s_tsd_hold;
    CE && $rose(THERMAL_SHUTDOWN) ##1 quiet [*4];
endsequence
sequence s_meas_read;
    CE && CURRENT_RESULT_WRITTEN ##1 quiet
        ##1 quiet && REG_RD && REG_ADDR == `PTIF_ADDR_FLAGS_HIGH;
endsequence
AST_TSD_TRIP: assert property (CE && $rose(THERMAL_SHUTDOWN) |=> all_off)
    else $error("thermal trip left outputs on");
AST_TSD_BLOCK: assert property (s_tsd_hold |-> REGULATOR_ENABLE == 0)
    else $error("regulator enabled while shutdown flag set");
AST_OVP_TRIP: assert property (CE && $rose(INPUT_OVERVOLTAGE) |=> all_off)
    else $error("overvoltage trip left outputs on");
AST_RESET_PULSE: assert property (CE && (HOST_RESET_REQUEST || $rose(ANALOG_SUPPLY_LOW))
    |=> REGISTERS_DEFAULT)
    else $error("reset event gave no default pulse");
AST_RESET_OFF: assert property (REGISTERS_DEFAULT |-> all_off)
    else $error("reset event left outputs on");
AST_RESTART: assert property (REGISTERS_DEFAULT == STARTUP_RESTART)
    else $error("restart pulse not paired with default pulse");
AST_RESERVED: assert property (CE && REG_RD && REG_ADDR == `PTIF_ADDR_FLAGS_LOW
    |=> REG_RDATA[7:1] == 7'h00)
    else $error("reserved bits read nonzero");
AST_STATUS: assert property (CE && REG_RD && REG_ADDR == `PTIF_ADDR_TOP_STATUS
    && $stable(THERMAL_SHUTDOWN) && $stable(THERMAL_WARNING)
    |=> REG_RDATA[3:2] == {$past(THERMAL_SHUTDOWN), $past(THERMAL_WARNING)})
    else $error("live status bits wrong");
AST_MEAS: assert property (s_meas_read |=> REG_RDATA[0])
    else $error("result flag not set");
endmodule // ptif_monitor
bind ptif_top ptif_monitor #(.NUM_REG(NUM_REG)) u_mon (
    .CLK                    (CLK),
    .RESETN                 (RESETN),
    .CE                     (CE),
    .REG_ADDR               (REG_ADDR),
    .REG_WR                 (REG_WR),
    .REG_RD                 (REG_RD),
    .REG_RDATA              (REG_RDATA),
    .THERMAL_SHUTDOWN       (THERMAL_SHUTDOWN),
    .THERMAL_WARNING        (THERMAL_WARNING),
    .INPUT_OVERVOLTAGE      (INPUT_OVERVOLTAGE),
    .CURRENT_RESULT_WRITTEN (CURRENT_RESULT_WRITTEN),
    .ANALOG_SUPPLY_LOW      (ANALOG_SUPPLY_LOW),
    .HOST_RESET_REQUEST     (HOST_RESET_REQUEST),
    .REGULATOR_ENABLE       (REGULATOR_ENABLE),
    .GENERAL_OUTPUT_A       (GENERAL_OUTPUT_A),
    .GENERAL_OUTPUT_B       (GENERAL_OUTPUT_B),
    .REGISTERS_DEFAULT      (REGISTERS_DEFAULT),
    .STARTUP_RESTART        (STARTUP_RESTART)
);

/* File: verification/ptif_host.sv */
// Host model driving the register byte port
`timescale 1ns/1ns
module ptif_host (
    input  wire       CLK,
    output reg  [7:0] REG_ADDR = 8'h00,
    output reg        REG_WR = 1'b0,
    output reg  [7:0] REG_WDATA = 8'h00,
    output reg        REG_RD = 1'b0,
    input  wire [7:0] REG_RDATA
);
// Flags are cleared by writing ones; reserved bits are written zero
task wr(input [7:0] a, input [7:0] d);
    @(posedge CLK);
    REG_ADDR <= a;
    REG_WDATA <= d;
    REG_WR <= 1'b1;
    @(posedge CLK);
    REG_WR <= 1'b0;
    REG_WDATA <= ~d;
endtask
task rd(input [7:0] a, output [7:0] d);
    @(posedge CLK);
    REG_ADDR <= a;
    REG_RD <= 1'b1;
    @(posedge CLK);
    REG_RD <= 1'b0;
    #1;
    d = REG_RDATA;
endtask
endmodule // ptif_host

/* File: verification/pmic_top_interrupt_flags_bench.sv */
// Self-checking bench for the top interrupt flag block
`timescale 1ns/1ns
module pmic_top_interrupt_flags_bench;
reg        clk = 0, rst_n = 0, sync = 0, tsd = 0, warn = 0, ovp = 0, meas = 0, low = 0;
reg        hrst = 0, oreq = 0, ce = 1;
reg  [3:0] req = 0;
wire [7:0] addr, wdata, rdata;
wire       wr, rd, ga, gb, dflt, restart;
wire [3:0] en;
wire [7:0] outs = {ga, gb, 2'b00, en};
integer    fails = 0, check_count = 0;
ptif_top dut (.CLK(clk), .RESETN(rst_n), .CE(ce), .REG_ADDR(addr), .REG_WR(wr),
    .REG_WDATA(wdata), .REG_RD(rd), .REG_RDATA(rdata), .SYNC_CLK_PRESENT(sync),
    .THERMAL_SHUTDOWN(tsd), .THERMAL_WARNING(warn), .INPUT_OVERVOLTAGE(ovp),
    .CURRENT_RESULT_WRITTEN(meas), .ANALOG_SUPPLY_LOW(low), .HOST_RESET_REQUEST(hrst),
    .REGULATOR_REQUEST(req), .REGULATOR_ENABLE(en), .GENERAL_OUTPUT_A_REQUEST(oreq),
    .GENERAL_OUTPUT_B_REQUEST(oreq), .GENERAL_OUTPUT_A(ga), .GENERAL_OUTPUT_B(gb),
    .REGISTERS_DEFAULT(dflt), .STARTUP_RESTART(restart));
ptif_host host (.CLK(clk), .REG_ADDR(addr), .REG_WR(wr), .REG_WDATA(wdata), .REG_RD(rd),
    .REG_RDATA(rdata));
// ----
// Helpers
// ----
task chk(input [7:0] got, input [7:0] exp);
    check_count = check_count + 1;
    if (got !== exp) begin
        fails = fails + 1;
        $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
endtask
task rchk(input [7:0] a, input [7:0] exp);
    reg [7:0] d;
    host.rd(a, d);
    chk(d, exp);
endtask
task settle;
    @(posedge clk);
    #1;
endtask
// Enables react only to a fresh request edge
task rereq;
    @(posedge clk) req <= 4'h0;
    @(posedge clk) req <= 4'hf;
    settle;
endtask
task final_report;
    $display("errors %0d checks %0d", fails, check_count);
    if (fails == 0 && check_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
endtask
task t_tsd;
    @(posedge clk) oreq <= 1'b1;
    rereq;
    chk(outs, 8'hcf);
    @(posedge clk) tsd <= 1'b1;
    settle;
    chk(outs, 8'h00);
    rereq;
    chk(outs, 8'h00);
    rchk(8'h19, 8'h08);
    rchk(8'h1d, 8'h08);
    @(posedge clk) tsd <= 1'b0;
    rchk(8'h1d, 8'h00);
    rchk(8'h19, 8'h08);
    host.wr(8'h19, 8'h08);
    rchk(8'h19, 8'h00);
    rereq;
    chk(outs, 8'h0f);
endtask
task t_ovp;
    @(posedge clk) warn <= 1'b1;
    rchk(8'h19, 8'h04);
    rchk(8'h1d, 8'h04);
    host.wr(8'h19, 8'h00);
    rchk(8'h19, 8'h04);
    host.wr(8'h19, 8'h04);
    rchk(8'h19, 8'h00);
    @(posedge clk) warn <= 1'b0;
    @(posedge clk) warn <= 1'b1;
    rchk(8'h19, 8'h04);
    @(posedge clk) warn <= 1'b0;
    host.wr(8'h19, 8'h04);
    @(posedge clk) ovp <= 1'b1;
    settle;
    chk(outs, 8'h00);
    rchk(8'h19, 8'h02);
    @(posedge clk) ovp <= 1'b0;
    host.wr(8'h19, 8'h02);
endtask
task t_meas;
    @(posedge clk) meas <= 1'b1;
    @(posedge clk) meas <= 1'b0;
    rchk(8'h19, 8'h01);
    host.wr(8'h19, 8'h01);
    rchk(8'h19, 8'h00);
    @(posedge clk) sync <= 1'b1;
    rchk(8'h19, 8'h10);
    host.wr(8'h19, 8'h10);
    @(posedge clk) sync <= 1'b0;
    rchk(8'h19, 8'h10);
    host.wr(8'h19, 8'h10);
    rchk(8'h55, 8'h00);
endtask
// A result pulse while CE is low is not seen
task t_ce;
    @(posedge clk) begin
        ce <= 1'b0;
        meas <= 1'b1;
    end
    @(posedge clk) meas <= 1'b0;
    @(posedge clk) ce <= 1'b1;
    rchk(8'h19, 8'h00);
endtask
task t_reset;
    @(posedge clk) meas <= 1'b1;
    @(posedge clk) meas <= 1'b0;
    rereq;
    @(posedge clk) hrst <= 1'b1;
    @(posedge clk) hrst <= 1'b0;
    #1;
    chk({outs[3:0], 2'b00, dflt, restart}, 8'h03);
    rchk(8'h1a, 8'h01);
    rchk(8'h19, 8'h00);
    host.wr(8'h1a, 8'h00);
    rchk(8'h1a, 8'h01);
    host.wr(8'h1a, 8'h01);
    rchk(8'h1a, 8'h00);
    @(posedge clk) low <= 1'b1;
    settle;
    chk({6'h00, dflt, restart}, 8'h03);
    rchk(8'h1a, 8'h01);
    @(posedge clk) low <= 1'b0;
endtask
initial forever #5 clk = ~clk;
initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    t_tsd;
    t_ovp;
    t_meas;
    t_ce;
    t_reset;
    final_report;
end
initial begin
    #100000;
    fails = fails + 1;
    final_report;
end
endmodule // pmic_top_interrupt_flags_bench
